/* File: fpec_ctrl.v */
// Flash program/erase sequencer with its special-function registers.
// Assumes the core bus and the Flash array share i_clk; Flash read data
// is valid while the read strobe is high.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defs.vh"

module fpec_ctrl (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // Special-function register bus
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_wr,
   input wire i_sfr_rd,
   input wire [7:0] i_sfr_wdata,
   output reg [7:0] o_sfr_rdata,
   // Flash array
   input wire [7:0] i_fl_rdata,
   output reg o_fl_sel,
   output reg o_fl_pgm,
   output reg o_fl_erase,
   output reg o_fl_vfy,
   output reg o_fl_pbuf,
   output reg o_fl_otp,
   output reg o_fl_bulk,
   output reg o_fl_hv,
   output reg [23:0] o_fl_addr,
   output reg [7:0] o_fl_wdata,
   output reg o_fl_wr,
   output reg o_fl_rd,
   output reg o_fl_pbuf_clr,
   output reg o_prog_mode
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_TIME = 2'h1;
   localparam ST_VRD = 2'h2;
   localparam ST_VCAP = 2'h3;

   // ----------------------------------------
   // CRC step, used by auto-verify captures only
   // ----------------------------------------
   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      integer k;
      reg [15:0] r;
      begin
         r = c ^ {d, 8'h00};
         for (k = 0; k < 8; k = k + 1) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ `FPEC_CRC_POLY) : {r[14:0], 1'b0};
         end
         crc_byte = r;
      end
   endfunction

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   reg [7:0] mode_q;
   reg [7:0] time_q;
   reg [23:0] addr_q;
   reg [7:0] data_q;
   reg [7:0] cmd_q;
   reg done_q;
   reg vgood_q;
   reg crcsel_q;
   reg irq_q;
   reg key_q;
   reg bulk_q;
   reg [1:0] st_q;
   reg [6:0] pre_q;
   reg [9:0] cnt_q;
   reg [5:0] vcnt_q;
   reg [23:0] rsum_q;
   reg [23:0] wsum_q;
   reg [15:0] crc_q;
   reg brd_q;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire wr_mode = i_sfr_wr && (i_sfr_addr == `FPEC_A_MODE);
   wire wr_stat = i_sfr_wr && (i_sfr_addr == `FPEC_A_STAT);
   wire wr_time = i_sfr_wr && (i_sfr_addr == `FPEC_A_TIME);
   wire wr_adrh = i_sfr_wr && (i_sfr_addr == `FPEC_A_ADRH);
   wire wr_adrm = i_sfr_wr && (i_sfr_addr == `FPEC_A_ADRM);
   wire wr_adrl = i_sfr_wr && (i_sfr_addr == `FPEC_A_ADRL);
   wire wr_data = i_sfr_wr && (i_sfr_addr == `FPEC_A_DATA);
   wire wr_cmd = i_sfr_wr && (i_sfr_addr == `FPEC_A_CMD);

   wire m_pgm = mode_q[`FPEC_M_PGM];
   wire m_ers = mode_q[`FPEC_M_ERS];
   wire m_vfy = mode_q[`FPEC_M_VFY];
   wire m_pbuf = mode_q[`FPEC_M_PBUF];
   wire m_wen = mode_q[`FPEC_M_WEN];
   wire ph_w = m_pgm && !m_vfy; // [R02] [R11]
   wire ph_e = m_ers && !m_vfy; // [R03] [R11]
   wire ph_v = m_vfy && (m_pgm || m_ers); // [R04] [R11]
   wire any_mode = m_pgm || m_ers || m_vfy;
   wire may_write = o_prog_mode && m_wen; // [R07]

   wire c_write = cmd_q[`FPEC_C_WRITE];
   wire c_read = cmd_q[`FPEC_C_READ];
   wire c_lrst = cmd_q[`FPEC_C_LRST];
   wire c_pbrst = cmd_q[`FPEC_C_PBRST];
   wire c_exit = cmd_q[`FPEC_C_EXIT1] && cmd_q[`FPEC_C_EXIT0]; // [R20]

   wire idle = (st_q == ST_IDLE);
   wire start_pe = idle && c_write && (ph_w || ph_e) && may_write;
   wire start_v = idle && c_read && ph_v; // [R21]
   wire start_op = start_pe || start_v;
   wire tick = (pre_q == `FPEC_PRE_LAST); // [R12]
   // Last count index: (t+1)*2-1 or (t+1)*4-1, both fit in 10 bits
   wire [9:0] tgt = bulk_q ? {time_q, 2'b11} : {1'b0, time_q, 1'b1}; // [R13] [R14]
   wire pe_end = (st_q == ST_TIME) && tick && (cnt_q == tgt);
   wire v_end = (st_q == ST_VCAP) && (vcnt_q == `FPEC_PAGE_LAST);
   wire op_end = pe_end || v_end;
   wire [23:0] rsum_n = rsum_q + {16'h0000, i_fl_rdata};

   // ----------------------------------------
   // Register writes and self-clearing bits
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         mode_q <= `FPEC_R_ZERO;
         time_q <= `FPEC_R_ZERO;
         data_q <= `FPEC_R_ZERO;
         cmd_q <= `FPEC_R_ZERO;
         crcsel_q <= 1'b0;
         key_q <= 1'b0;
         o_prog_mode <= 1'b0;
         bulk_q <= 1'b0;
      end else begin
         // Command bits live one clock only
         cmd_q <= wr_cmd ? (i_sfr_wdata & `FPEC_CMD_MASK) : `FPEC_R_ZERO; // [R20] [R21] [R22] [R23]
         if (wr_mode) begin
            mode_q <= i_sfr_wdata;
         end
         if (wr_time) begin
            time_q <= i_sfr_wdata;
         end
         if (wr_stat) begin
            crcsel_q <= i_sfr_wdata[`FPEC_S_CRC];
         end
         if (start_pe) begin
            bulk_q <= cmd_q[`FPEC_C_BULK]; // [R14] [R26]
         end
         if (wr_data) begin
            data_q <= i_sfr_wdata;
            key_q <= (i_sfr_wdata == `FPEC_KEY1); // [R19]
            if (key_q && (i_sfr_wdata == `FPEC_KEY2)) begin
               o_prog_mode <= 1'b1; // [R19]
            end
         end else if (brd_q) begin
            data_q <= i_fl_rdata; // [R18]
         end
         // Control reset keeps program mode; only the exit pair leaves it
         if (c_exit) begin
            o_prog_mode <= 1'b0; // [R20]
         end
         if (c_exit || c_lrst) begin
            key_q <= 1'b0; // [R22]
         end
      end
   end

   // ----------------------------------------
   // Sequencer, timer and flags
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= ST_IDLE;
         pre_q <= 7'h00;
         cnt_q <= 10'h000;
         vcnt_q <= 6'h00;
         done_q <= 1'b1;
         vgood_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (c_lrst && !start_op) begin
         // Abort leaves the array idle; the start pattern carries this bit too
         st_q <= ST_IDLE; // [R22]
         pre_q <= 7'h00;
         cnt_q <= 10'h000;
         done_q <= 1'b1;
      end else begin
         if (wr_stat) begin
            vgood_q <= i_sfr_wdata[`FPEC_S_VGOOD];
            irq_q <= i_sfr_wdata[`FPEC_S_IRQ];
         end
         if (start_op) begin
            done_q <= 1'b0; // [R08]
            irq_q <= 1'b0; // [R10]
            pre_q <= 7'h00; // [R12]
            cnt_q <= 10'h000; // [R12]
            vcnt_q <= 6'h00;
            st_q <= start_pe ? ST_TIME : ST_VRD;
         end
         case (st_q)
            ST_IDLE: begin
            end
            ST_TIME: begin
               pre_q <= pre_q + 7'h01;
               if (tick && !pe_end) begin
                  cnt_q <= cnt_q + 10'h001; // [R12]
               end
            end
            ST_VRD: begin
               st_q <= ST_VCAP;
            end
            ST_VCAP: begin
               vcnt_q <= vcnt_q + 6'h01;
               st_q <= v_end ? ST_IDLE : ST_VRD; // [R24]
               if (v_end) begin
                  vgood_q <= (rsum_n == wsum_q); // [R09]
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
         if (pe_end) begin
            st_q <= ST_IDLE;
         end
         if (op_end) begin
            done_q <= 1'b1; // [R08] [R27]
            irq_q <= 1'b1; // [R10] [R27]
         end
      end
   end

   // ----------------------------------------
   // Address, checksums and CRC
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         addr_q <= 24'h000000;
         rsum_q <= 24'h000000;
         wsum_q <= 24'h000000;
         crc_q <= `FPEC_CRC_INIT;
      end else begin
         if (wr_adrh) begin
            addr_q[23:16] <= i_sfr_wdata;
         end
         if (wr_adrm) begin
            addr_q[15:8] <= i_sfr_wdata;
         end
         if (wr_adrl) begin
            addr_q[7:0] <= i_sfr_wdata;
         end
         if (start_v) begin
            rsum_q <= 24'h000000;
            crc_q <= `FPEC_CRC_INIT;
         end
         if (st_q == ST_VCAP) begin
            rsum_q <= rsum_n; // [R17]
            crc_q <= crc_byte(crc_q, i_fl_rdata); // [R17]
            addr_q <= addr_q + 24'h000001; // [R16]
         end
         // Buffer loads advance the address and feed the write checksum
         if (wr_data && m_pbuf && o_prog_mode) begin
            wsum_q <= wsum_q + {16'h0000, i_sfr_wdata};
            addr_q <= addr_q + 24'h000001;
         end
         if (c_pbrst && m_pbuf) begin
            wsum_q <= 24'h000000; // [R23]
         end
      end
   end

   // ----------------------------------------
   // Flash array strobes, all registered
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_fl_sel <= 1'b0;
         o_fl_pgm <= 1'b0;
         o_fl_erase <= 1'b0;
         o_fl_vfy <= 1'b0;
         o_fl_pbuf <= 1'b0;
         o_fl_otp <= 1'b0;
         o_fl_bulk <= 1'b0;
         o_fl_hv <= 1'b0;
         o_fl_addr <= 24'h000000;
         o_fl_wdata <= `FPEC_R_ZERO;
         o_fl_wr <= 1'b0;
         o_fl_rd <= 1'b0;
         o_fl_pbuf_clr <= 1'b0;
         brd_q <= 1'b0;
      end else begin
         o_fl_sel <= mode_q[`FPEC_M_SEL]; // [R01]
         o_fl_pgm <= ph_w && may_write; // [R02] [R07]
         o_fl_erase <= ph_e && may_write; // [R03] [R07]
         o_fl_vfy <= ph_v; // [R04]
         o_fl_pbuf <= m_pbuf; // [R05]
         o_fl_otp <= mode_q[`FPEC_M_OTP]; // [R06]
         // Launched with the start so the strobe spans the whole count
         o_fl_bulk <= start_pe ? cmd_q[`FPEC_C_BULK] : ((st_q == ST_TIME) && !pe_end && bulk_q); // [R14]
         o_fl_hv <= start_pe || ((st_q == ST_TIME) && !pe_end); // [R13]
         // Program and erase see only the page number
         if (ph_w || ph_e) begin
            o_fl_addr <= {addr_q[23:`FPEC_PAGE_BITS], {`FPEC_PAGE_BITS{1'b0}}}; // [R15] [R24]
         end else begin
            o_fl_addr <= addr_q;
         end
         o_fl_pbuf_clr <= c_pbrst && !m_pbuf; // [R23]
         o_fl_wdata <= wr_data ? i_sfr_wdata : data_q;
         // Buffer loads and idle byte writes share the write strobe
         o_fl_wr <= (wr_data && m_pbuf && o_prog_mode)
            || (idle && c_write && !any_mode && may_write); // [R05] [R18]
         brd_q <= idle && c_read && !any_mode; // [R18]
         o_fl_rd <= (idle && c_read && !any_mode) || (st_q == ST_VRD); // [R16] [R18]
      end
   end

   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_sfr_rdata <= `FPEC_R_ZERO;
      end else if (i_sfr_rd) begin
         case (i_sfr_addr)
            `FPEC_A_MODE: o_sfr_rdata <= mode_q;
            `FPEC_A_STAT: o_sfr_rdata <= {done_q, vgood_q, crcsel_q, 1'b0, irq_q, ph_w, ph_e, ph_v}; // [R08] [R11]
            `FPEC_A_TIME: o_sfr_rdata <= time_q;
            `FPEC_A_ADRH: o_sfr_rdata <= crcsel_q ? `FPEC_R_ZERO : rsum_q[23:16]; // [R17]
            `FPEC_A_ADRM: o_sfr_rdata <= crcsel_q ? crc_q[15:8] : rsum_q[15:8]; // [R17]
            `FPEC_A_ADRL: o_sfr_rdata <= crcsel_q ? crc_q[7:0] : rsum_q[7:0]; // [R17]
            `FPEC_A_DATA: o_sfr_rdata <= data_q;
            `FPEC_A_CMD: o_sfr_rdata <= cmd_q;
            default: o_sfr_rdata <= `FPEC_R_ZERO;
         endcase
      end
   end

endmodule // fpec_ctrl
`default_nettype wire

/* File: fpec_ctrl_properties.sv */
// Port checker for the flash program/erase sequencer.
// Assumes it is bound to fpec_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fpec_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Register bus
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   // Flash side
   input wire logic o_fl_sel,
   input wire logic o_fl_pgm,
   input wire logic o_fl_erase,
   input wire logic o_fl_pbuf,
   input wire logic o_fl_bulk,
   input wire logic o_fl_hv,
   input wire logic [23:0] o_fl_addr,
   input wire logic [7:0] o_fl_wdata,
   input wire logic o_fl_wr,
   input wire logic o_fl_pbuf_clr,
   input wire logic o_prog_mode
);
// ----------------------------------------
// Helpers
// ----------------------------------------
default clocking cb @(posedge i_clk);
endclocking
default disable iff (!i_rst_n);
logic [7:0] t_q;
logic [17:0] n_q;
logic ab_q;
wire w_cmd = i_sfr_wr && i_sfr_addr == 8'hF6;
wire key2 = i_sfr_wr && i_sfr_addr == 8'hF5 && i_sfr_wdata == 8'h5A;
// Shadow of the time register, so the span can be judged
always_ff @(posedge i_clk) begin
   if (!i_rst_n) begin
      t_q <= 8'h00;
   end else if (i_sfr_wr && i_sfr_addr == 8'hEC) begin
      t_q <= i_sfr_wdata;
   end
   n_q <= o_fl_hv ? n_q + 18'h1 : 18'h0;
   // An aborted run ends short on purpose
   ab_q <= o_fl_hv && (ab_q || (w_cmd && i_sfr_wdata[1]));
end
// ----------------------------------------
// Properties
// ----------------------------------------
property p_sel;
   i_sfr_wr && i_sfr_addr == 8'hEA |-> ##2 o_fl_sel == $past(i_sfr_wdata[7], 2);
endproperty
a_sel: assert property (p_sel) else $error("select does not follow mode");
property p_align;
   o_fl_hv |-> o_fl_addr[5:0] == 6'h00;
endproperty
a_align: assert property (p_align) else $error("timed op address not page aligned");
property p_hven;
   o_fl_hv |-> o_fl_pgm || o_fl_erase;
endproperty
a_hven: assert property (p_hven) else $error("timed op without enabled phase");
property p_time;
   $fell(o_fl_hv) && !ab_q |-> n_q == (t_q + 18'h1) * ($past(o_fl_bulk) ? 18'h200 : 18'h100);
endproperty
a_time: assert property (p_time) else $error("timed op length wrong");
property p_entry;
   $rose(o_prog_mode) |-> $past(key2) || $past(key2, 2);
endproperty
a_entry: assert property (p_entry) else $error("program mode without key");
property p_exit;
   o_prog_mode && !o_fl_hv && w_cmd && i_sfr_wdata[5:4] == 2'b11 |-> ##[1:3] !o_prog_mode;
endproperty
a_exit: assert property (p_exit) else $error("exit not taken");
property p_keep;
   o_prog_mode && w_cmd && i_sfr_wdata[5:4] != 2'b11 && !i_sfr_wdata[1] |=> o_prog_mode [*2];
endproperty
a_keep: assert property (p_keep) else $error("left program mode on partial exit");
property p_clr;
   o_prog_mode && !o_fl_hv && !o_fl_pbuf && w_cmd && i_sfr_wdata[0] |-> ##[1:2] o_fl_pbuf_clr;
endproperty
a_clr: assert property (p_clr) else $error("buffer clear missing");
property p_load;
   i_sfr_wr && i_sfr_addr == 8'hF5 && o_prog_mode && o_fl_pbuf |=> o_fl_wr && o_fl_wdata == $past(i_sfr_wdata);
endproperty
a_load: assert property (p_load) else $error("buffer load not passed on");
c_bulk: cover property ($fell(o_fl_hv) && $past(o_fl_bulk));
c_entry: cover property ($rose(o_prog_mode));
c_clr: cover property (o_fl_pbuf_clr);
endmodule // fpec_chk
bind fpec_ctrl fpec_chk u_chk (.*);
`default_nettype wire

/* File: fpec_ctrl_tb.sv */
// Self-checking bench for the flash sequencer.
// Assumes fpec_ctrl, its checker and the array model.
`timescale 1ns/1ps
`default_nettype none
module fpec_ctrl_tb;
// ----------------------------------------
// Harness
// ----------------------------------------
logic clk = 1'b0;
logic rst_n = 1'b0;
logic [7:0] addr = 8'h00;
logic swr = 1'b0;
logic srd = 1'b0;
logic [7:0] wd = 8'h00;
logic [7:0] s;
wire [7:0] rdata;
wire [7:0] frd;
wire [23:0] fa;
wire sel, program_enable, ers, verify_enable, pbuf, otp, hv, frdp, pm;
int fail_count = 0;
int cmp_count = 0;
int sum;
always #12.5 clk = ~clk;
fpec_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(swr), .i_sfr_rd(srd),
   .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .i_fl_rdata(frd), .o_fl_sel(sel), .o_fl_pgm(program_enable),
   .o_fl_erase(ers), .o_fl_vfy(verify_enable), .o_fl_pbuf(pbuf), .o_fl_otp(otp), .o_fl_bulk(),
   .o_fl_hv(hv), .o_fl_addr(fa), .o_fl_wdata(), .o_fl_wr(), .o_fl_rd(frdp),
   .o_fl_pbuf_clr(), .o_prog_mode(pm));
fpec_flash_model u_flash (.i_rd(frdp), .i_addr(fa), .o_rdata(frd));
// ----------------------------------------
// Bus tasks
// ----------------------------------------
task automatic bw(input logic [7:0] a, input logic [7:0] d);
   @(negedge clk);
   addr = a;
   wd = d;
   swr = 1'b1;
   @(negedge clk);
   swr = 1'b0;
endtask
task automatic br(input logic [7:0] a, output logic [7:0] d);
   @(negedge clk);
   addr = a;
   srd = 1'b1;
   @(negedge clk);
   srd = 1'b0;
   @(negedge clk);
   d = rdata;
endtask
task automatic chk(input logic [7:0] g, input logic [7:0] e);
   cmp_count++;
   if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
   end
endtask
task automatic summarize;
   $display("checks %0d mismatches %0d", cmp_count, fail_count);
   if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
   end else begin
      $display("TB: FAIL");
   end
   $finish;
endtask
// Bounded poll; a hang ends the run here
task automatic wait_done;
   int n;
   n = 0;
   s = 8'h00;
   while (s[7] !== 1'b1 && n < 500) begin
      br(8'hEB, s);
      n++;
   end
   if (s[7] !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: no completion", $time);
      summarize();
   end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_reset;
   logic [7:0] ra [6] = '{8'hEA, 8'hEB, 8'hEC, 8'hF2, 8'hF6, 8'hE0};
   logic [7:0] rv [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
   for (int i = 0; i < 6; i++) begin
      br(ra[i], s);
      chk(s, rv[i]);
   end
   $display("test reset done");
endtask
task automatic t_entry;
   bw(8'hF5, 8'hA5);
   bw(8'hF5, 8'h11);
   bw(8'hF5, 8'h5A);
   @(negedge clk);
   chk({7'h00, pm}, 8'h00);
   bw(8'hF5, 8'hA5);
   bw(8'hF5, 8'h5A);
   @(negedge clk);
   chk({7'h00, pm}, 8'h01);
   bw(8'hF6, 8'h10);
   bw(8'hF6, 8'h20);
   br(8'hF6, s);
   chk({s[7:1], pm}, 8'h01);
   bw(8'hF6, 8'h30);
   repeat (2) @(negedge clk);
   chk({7'h00, pm}, 8'h00);
   bw(8'hF5, 8'hA5);
   bw(8'hF5, 8'h5A);
   @(negedge clk);
   chk({7'h00, pm}, 8'h01);
   $display("test entry done");
endtask
task automatic t_mode;
   logic [7:0] mv [8] = '{8'h80, 8'hA1, 8'hA0, 8'hA3, 8'h91, 8'h93, 8'h8C, 8'h00};
   logic [8:0] ev [8] = '{9'h100, 9'h184, 9'h104, 9'h121, 9'h142, 9'h121, 9'h118, 9'h000};
   for (int i = 0; i < 8; i++) begin
      bw(8'hEA, mv[i]);
      br(8'hEB, s);
      chk({2'b00, sel, program_enable, ers, verify_enable, pbuf, otp}, {2'b00, ev[i][8:3]});
      chk({5'h00, s[2:0]}, {5'h00, ev[i][2:0]});
   end
   $display("test mode done");
endtask
task automatic t_page;
   sum = 0;
   bw(8'hEA, 8'h81);
   bw(8'hF6, 8'h01);
   bw(8'hEA, 8'h89);
   for (int i = 0; i < 64; i++) begin
      bw(8'hF5, 8'h7C ^ i[7:0]);
      sum = sum + (8'h7C ^ i[7:0]);
   end
   bw(8'hEA, 8'hA1);
   bw(8'hF2, 8'h00);
   bw(8'hF3, 8'h01);
   bw(8'hF4, 8'h47);
   bw(8'hEC, 8'h00);
   bw(8'hF6, 8'h0B);
   br(8'hEB, s);
   chk(s & 8'h88, 8'h00);
   wait_done;
   chk(s & 8'h88, 8'h88);
   bw(8'hEB, 8'h00);
   br(8'hEB, s);
   chk(s & 8'h88, 8'h80);
   bw(8'hEA, 8'h91);
   bw(8'hEC, 8'h01);
   bw(8'hF6, 8'h8B);
   wait_done;
   chk(s & 8'h88, 8'h88);
   $display("test page done");
endtask
task automatic t_verify;
   logic [15:0] crc;
   logic [7:0] b;
   // CRC-16 of the bytes the array model returns for 0x40..0x7F
   crc = 16'hFFFF;
   for (int i = 0; i < 64; i++) begin
      b = (8'h40 + i[7:0]) ^ 8'h3C;
      crc = crc ^ {b, 8'h00};
      for (int k = 0; k < 8; k++) begin
         crc = crc[15] ? ({crc[14:0], 1'b0} ^ 16'h1021) : {crc[14:0], 1'b0};
      end
   end
   bw(8'hEA, 8'hA3);
   bw(8'hF4, 8'h40);
   bw(8'hF6, 8'h04);
   wait_done;
   chk(s & 8'hC8, 8'hC8);
   br(8'hF6, s);
   chk(s, 8'h00);
   br(8'hF2, s);
   chk(s, sum[23:16]);
   br(8'hF3, s);
   chk(s, sum[15:8]);
   br(8'hF4, s);
   chk(s, sum[7:0]);
   bw(8'hEB, 8'h28);
   br(8'hF2, s);
   chk(s, 8'h00);
   br(8'hF3, s);
   chk(s, crc[15:8]);
   br(8'hF4, s);
   chk(s, crc[7:0]);
   bw(8'hEA, 8'h89);
   bw(8'hF6, 8'h01);
   bw(8'hEA, 8'hA3);
   bw(8'hF4, 8'h40);
   bw(8'hF6, 8'h04);
   br(8'hEB, s);
   chk(s & 8'h88, 8'h00);
   wait_done;
   chk(s & 8'h40, 8'h00);
   bw(8'hEA, 8'hA1);
   bw(8'hF6, 8'h0B);
   bw(8'hF6, 8'h02);
   br(8'hEB, s);
   chk(s & 8'h8F, 8'h84);
   chk({7'h00, pm}, 8'h01);
   bw(8'hEA, 8'h80);
   bw(8'hF4, 8'h55);
   bw(8'hF6, 8'h04);
   repeat (2) @(negedge clk);
   br(8'hF5, s);
   chk(s, 8'h69);
   $display("test verify done");
endtask
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial begin
   repeat (10) @(negedge clk);
   rst_n = 1'b1;
   t_reset;
   t_entry;
   t_mode;
   t_page;
   t_verify;
   summarize;
end
endmodule // fpec_ctrl_tb
`default_nettype wire

/* File: fpec_defs.vh */
// Constants for the flash program/erase control block.
// Assumes one 40 MHz clock shared with the special-function register bus.
//
// Contract
// R01: Select bit selects or deselects Flash.
// R02: Program bit enables programming; with verify, verifies.
// R03: Erase bit enables erase and erase verify.
// R04: Verify plus program/erase picks verify kind; the code drives only o_fl_vfy and ph_v, the same for both kinds.
// R05: Page buffer select routes accesses to buffer.
// R06: Area select targets one-time-programmable area.
// R07: Program/erase only with write enable set.
// R08: Done flag low while busy, resets high.
// R09: Verify flag shows auto-verify pass or fail.
// R10: Interrupt flag set at end, cleared at start.
// R11: Read-only write, erase, verify phase flags.
// R12: 10-bit timer on clock/128, cleared at start.
// R13: Page operation lasts (t+1)*2*128 clocks.
// R14: Bulk erase lasts (t+1)*4*128 clocks.
// R15: Page address ignores in-page byte bits.
// R16: Auto-verify increments address per byte.
// R17: Address reads return checksum or CRC.
// R18: Idle read/write commands move single bytes.
// R19: Data writes A5 then 5A enter program mode.
// R20: Only both exit bits leave; self-clear.
// R21: Read command starts auto-verify, self-clears.
// R22: Control reset bit resets logic, self-clears.
// R23: Buffer reset clears buffer or checksum.
// R24: Pages hold 64 bytes.
// R25: Host starts page operation and polls done.
// R26: Host starts bulk erase with bulk bit.
// R27: Done and interrupt flags set together; a control reset abort sets done without the interrupt flag.
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FPEC_A_MODE 8'hEA
`define FPEC_A_STAT 8'hEB
`define FPEC_A_TIME 8'hEC
`define FPEC_A_ADRH 8'hF2
`define FPEC_A_ADRM 8'hF3
`define FPEC_A_ADRL 8'hF4
`define FPEC_A_DATA 8'hF5
`define FPEC_A_CMD 8'hF6

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define FPEC_M_SEL 7
`define FPEC_M_PGM 5
`define FPEC_M_ERS 4
`define FPEC_M_PBUF 3
`define FPEC_M_OTP 2
`define FPEC_M_VFY 1
`define FPEC_M_WEN 0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define FPEC_S_DONE 7
`define FPEC_S_VGOOD 6
`define FPEC_S_CRC 5
`define FPEC_S_IRQ 3
`define FPEC_S_WPH 2
`define FPEC_S_EPH 1
`define FPEC_S_VPH 0

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define FPEC_C_BULK 7
`define FPEC_C_EXIT1 5
`define FPEC_C_EXIT0 4
`define FPEC_C_WRITE 3
`define FPEC_C_READ 2
`define FPEC_C_LRST 1
`define FPEC_C_PBRST 0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define FPEC_R_ZERO 8'h00
`define FPEC_R_STAT 8'h80
`define FPEC_KEY1 8'hA5
`define FPEC_KEY2 8'h5A
`define FPEC_CMD_MASK 8'hBF
`define FPEC_CRC_POLY 16'h1021
`define FPEC_CRC_INIT 16'hFFFF

// ----------------------------------------
// Timing and geometry
// ----------------------------------------
`define FPEC_PRE_LAST 7'h7F
`define FPEC_PAGE_BITS 6
`define FPEC_PAGE_LAST 6'h3F

`endif

/* File: fpec_flash_model.sv */
// Behavioural Flash array facing the sequencer.
// Assumes read data is sampled while the read strobe is high.
`timescale 1ns/1ps
`default_nettype none
module fpec_flash_model (
   // Array port
   input wire logic i_rd,
   input wire logic [23:0] i_addr,
   output var logic [7:0] o_rdata
);
// ----------------------------------------
// Read path
// ----------------------------------------
// Off-strobe data is the inverse, so a capture outside the strobe cannot pass
always_comb begin
   o_rdata = i_rd ? (i_addr[7:0] ^ 8'h3C) : ~(i_addr[7:0] ^ 8'h3C);
end
endmodule // fpec_flash_model
`default_nettype wire
